/* rtl/ivm_pkg.sv */
// constants for the interrupt vector and mode control block
package ivm_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] MODE_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] CTRL_ADDR = 12'h008;

  // ==========================================================
  // global_interrupt_mode fields
  localparam int MODE_BIT = 15;
  localparam int VS7_BIT = 14;
  localparam int VS6_BIT = 13;
  localparam int VS1_BIT = 12;
  localparam int TT7_BIT = 10;
  localparam int TT6_BIT = 9;
  localparam int TT1_BIT = 8;
  localparam int VBASE_LSB = 5;
  localparam int VBASE_MSB = 7;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'hf7e0;

  // ==========================================================
  // control register fields
  localparam int CTRL_STROBE_EN_BIT = 0;
  localparam int CTRL_L4V_BIT = 1;
  localparam int CTRL_CPU_DIS_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // ==========================================================
  // status register fields
  localparam int STAT_P1_BIT = 0;
  localparam int STAT_P6_BIT = 1;
  localparam int STAT_P7_BIT = 2;
  localparam int STAT_LEVEL_LSB = 3;
  localparam int STAT_VEC_LSB = 8;

  // ==========================================================
  // vector encoding
  localparam logic [7:0] UNINIT_VECTOR = 8'h0f;
  localparam logic [4:0] CODE_LEVEL7 = 5'h17;
  localparam logic [4:0] CODE_LEVEL6 = 5'h16;
  localparam logic [4:0] CODE_LEVEL1 = 5'h11;
  localparam logic [4:0] CODE_ERROR = 5'h00;
  localparam logic [2:0] LEVEL_7 = 3'h7;
  localparam logic [2:0] LEVEL_6 = 3'h6;
  localparam logic [2:0] LEVEL_4 = 3'h4;
  localparam logic [2:0] LEVEL_1 = 3'h1;
  localparam logic [2:0] LEVEL_NONE = 3'h0;

  // ==========================================================
  // acknowledge cycle decode
  localparam logic [2:0] FC_IACK = 3'h7;
  localparam logic [3:0] ADDR_HI_IACK = 4'hf;

  typedef enum logic [1:0] {ST_IDLE, ST_DRIVE, ST_PASSIVE} ivm_ack_state_t;
endpackage

/* rtl/ivm_line_trigger.sv */
// one dedicated request line: synchroniser plus level/edge pending logic
`timescale 1ns/100ps
`default_nettype none
module ivm_line_trigger (
  input wire logic pclk,        // system clock
  input wire logic presetn,     // total system reset, active low
  input wire logic line_in_n,   // request pin, active low, asynchronous
  input wire logic edge_mode,   // 1 = falling edge, 0 = low level
  input wire logic ack_clear,   // acknowledge of this level, one cycle
  output logic pending          // request pending at this level
);
  logic sync_a;
  logic sync_b;
  logic prev_b;
  logic edge_latch;
  logic next_edge_latch;

  // ==========================================================
  // synchroniser, first stage read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      prev_b <= 1'b1;
    end else begin
      sync_a <= line_in_n;
      sync_b <= sync_a;
      prev_b <= sync_b;
    end
  end

  // ==========================================================
  // edges count only in edge mode, so no stale request shows on a mode switch
  always_comb begin
    next_edge_latch = edge_latch;
    if (ack_clear) begin
      next_edge_latch = 1'b0;
    end
    if (edge_mode && prev_b && !sync_b) begin
      next_edge_latch = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_latch <= 1'b0;
    end else begin
      edge_latch <= next_edge_latch;
    end
  end

  // level mode follows the pin, so negating the line withdraws the request
  assign pending = edge_mode ? edge_latch : !sync_b;
endmodule
`default_nettype wire

/* rtl/ivm_vector_ctrl.sv */
// interrupt vector generation, acknowledge decode and global mode register
`timescale 1ns/100ps
`default_nettype none
module ivm_vector_ctrl (
  input wire logic pclk,                      // system clock
  input wire logic presetn,                   // total system reset, active low
  input wire logic psel,                      // apb select
  input wire logic penable,                   // apb enable
  input wire logic pwrite,                    // apb direction
  input wire logic [11:0] paddr,              // apb byte address
  input wire logic [31:0] pwdata,             // apb write data
  output logic [31:0] prdata,                 // apb read data
  output logic pready,                        // apb ready
  output logic pslverr,                       // apb error on unmapped address
  input wire logic level7_request_in_n,       // dedicated level 7 pin
  input wire logic level6_request_in_n,       // dedicated level 6 pin
  input wire logic level1_request_in_n,       // dedicated level 1 pin
  input wire logic [2:0] encoded_priority_in_n, // encoded level pins
  input wire logic autovector_request_n,      // autovector pin
  input wire logic [15:0] internal_source_request, // pending unmasked level-4 sources
  input wire logic bus_addr_strobe,           // core address strobe
  input wire logic [2:0] bus_fc,              // core function code
  input wire logic [3:0] bus_addr_hi,         // core address bits 19..16
  input wire logic [2:0] bus_addr_lo,         // core address bits 3..1
  output logic [2:0] core_request_level,      // level presented to the core
  output logic [2:0] forwarded_request_out_n, // forwarded level, core disabled
  output logic [7:0] vector_data_out,         // vector onto data bus
  output logic vector_data_oe,                // data bus drive enable
  output logic dtack_out_n,                   // transfer acknowledge out
  output logic dtack_oe,                      // transfer acknowledge drive enable
  output logic level7_ack_strobe_n,           // level 7 acknowledge strobe
  output logic level6_ack_strobe_n,           // level 6 acknowledge strobe
  output logic level1_ack_strobe_n,           // level 1 acknowledge strobe
  output logic ack_strobe_pins_en,            // strobe pins own the port pins
  output logic internal_ack_valid,            // level-4 vector handed over
  output logic [4:0] internal_ack_code        // source code of that vector
);
  logic [15:0] global_interrupt_mode;
  logic [15:0] next_global_interrupt_mode;
  logic base_written;
  logic next_base_written;
  logic [2:0] port_b_control;
  logic [2:0] next_port_b_control;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [2:0] ipl_a;
  logic [2:0] ipl_b;
  logic avrq_a;
  logic avrq_b;
  logic pend7;
  logic pend6;
  logic pend1;
  logic [2:0] ext_level;
  logic [2:0] next_core_request_level;
  logic [2:0] next_forwarded_n;
  logic [4:0] int_code;
  logic iack_active;
  logic ack_start;
  logic [2:0] ack_level;
  ivm_pkg::ivm_ack_state_t state;
  ivm_pkg::ivm_ack_state_t next_state;
  logic supply;
  logic [4:0] low_code;
  logic [7:0] next_vector;
  logic next_vector_oe;
  logic next_dtack_n;
  logic next_dtack_oe;
  logic next_int_valid;
  logic [4:0] next_int_code;
  logic [2:0] next_strobe_n;
  logic apb_done;
  logic apb_hit_mode;
  logic apb_hit_stat;
  logic apb_hit_ctrl;
  logic dedicated;
  logic cpu_disabled;

  assign dedicated = global_interrupt_mode[ivm_pkg::MODE_BIT];
  assign cpu_disabled = port_b_control[ivm_pkg::CTRL_CPU_DIS_BIT];

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ipl_a <= 3'h7;
      ipl_b <= 3'h7;
      avrq_a <= 1'b1;
      avrq_b <= 1'b1;
    end else begin
      ipl_a <= encoded_priority_in_n;
      ipl_b <= ipl_a;
      avrq_a <= autovector_request_n;
      avrq_b <= avrq_a;
    end
  end

  // ==========================================================
  // dedicated request lines
  assign iack_active = bus_addr_strobe && (bus_fc == ivm_pkg::FC_IACK) &&
                       (bus_addr_hi == ivm_pkg::ADDR_HI_IACK);
  assign ack_level = bus_addr_lo;
  assign ack_start = iack_active && (state == ivm_pkg::ST_IDLE);

  ivm_line_trigger u_line7 (
    .pclk(pclk),
    .presetn(presetn),
    .line_in_n(level7_request_in_n),
    .edge_mode(global_interrupt_mode[ivm_pkg::TT7_BIT]),
    .ack_clear(ack_start && (ack_level == ivm_pkg::LEVEL_7)),
    .pending(pend7)
  );

  ivm_line_trigger u_line6 (
    .pclk(pclk),
    .presetn(presetn),
    .line_in_n(level6_request_in_n),
    .edge_mode(global_interrupt_mode[ivm_pkg::TT6_BIT]),
    .ack_clear(ack_start && (ack_level == ivm_pkg::LEVEL_6)),
    .pending(pend6)
  );

  ivm_line_trigger u_line1 (
    .pclk(pclk),
    .presetn(presetn),
    .line_in_n(level1_request_in_n),
    .edge_mode(global_interrupt_mode[ivm_pkg::TT1_BIT]),
    .ack_clear(ack_start && (ack_level == ivm_pkg::LEVEL_1)),
    .pending(pend1)
  );

  // ==========================================================
  // request level towards the core and forwarded pins
  always_comb begin
    ext_level = ivm_pkg::LEVEL_NONE;
    if (dedicated) begin
      if (pend7) begin
        ext_level = ivm_pkg::LEVEL_7;
      end else if (pend6) begin
        ext_level = ivm_pkg::LEVEL_6;
      end else if (pend1) begin
        ext_level = ivm_pkg::LEVEL_1;
      end
    end else begin
      ext_level = ~ipl_b;
    end
    next_core_request_level = ext_level;
    if (|internal_source_request[15:1] && (ext_level < ivm_pkg::LEVEL_4)) begin
      next_core_request_level = ivm_pkg::LEVEL_4;
    end
    next_forwarded_n = 3'h7;
    if (cpu_disabled) begin
      next_forwarded_n = ~next_core_request_level;
    end
  end

  // bit index equals the source code, bit 15 highest; bit 0 stays the error slot
  always_comb begin
    int_code = ivm_pkg::CODE_ERROR;
    for (int i = 1; i < 16; i++) begin
      if (internal_source_request[i]) begin
        int_code = 5'(i);
      end
    end
  end

  // ==========================================================
  // acknowledge cycle handling
  always_comb begin
    supply = 1'b0;
    low_code = ivm_pkg::CODE_ERROR;
    case (ack_level)
      ivm_pkg::LEVEL_7: begin
        supply = !global_interrupt_mode[ivm_pkg::VS7_BIT];
        low_code = ivm_pkg::CODE_LEVEL7;
      end
      ivm_pkg::LEVEL_6: begin
        supply = !global_interrupt_mode[ivm_pkg::VS6_BIT];
        low_code = ivm_pkg::CODE_LEVEL6;
      end
      ivm_pkg::LEVEL_1: begin
        supply = !global_interrupt_mode[ivm_pkg::VS1_BIT];
        low_code = ivm_pkg::CODE_LEVEL1;
      end
      ivm_pkg::LEVEL_4: begin
        // a disabled core leaves level-4 vectors to the host unless enabled
        supply = !cpu_disabled || port_b_control[ivm_pkg::CTRL_L4V_BIT];
        low_code = int_code;
      end
      default: begin
        supply = 1'b0;
        low_code = ivm_pkg::CODE_ERROR;
      end
    endcase
    // autovector overrides every vector except level 4, so stay off the bus for it
    if (!avrq_b && (ack_level != ivm_pkg::LEVEL_4)) begin
      supply = 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    next_vector = vector_data_out;
    next_vector_oe = vector_data_oe;
    next_dtack_n = dtack_out_n;
    next_dtack_oe = dtack_oe;
    next_int_valid = 1'b0;
    next_int_code = internal_ack_code;
    case (state)
      ivm_pkg::ST_IDLE: begin
        if (iack_active) begin
          if (supply) begin
            next_state = ivm_pkg::ST_DRIVE;
            next_vector = base_written ?
              {global_interrupt_mode[ivm_pkg::VBASE_MSB:ivm_pkg::VBASE_LSB], low_code} :
              ivm_pkg::UNINIT_VECTOR;
            next_vector_oe = 1'b1;
            next_dtack_n = 1'b0;
            next_dtack_oe = 1'b1;
            if (ack_level == ivm_pkg::LEVEL_4) begin
              next_int_valid = 1'b1;
              next_int_code = low_code;
            end
          end else begin
            next_state = ivm_pkg::ST_PASSIVE;
          end
        end
      end
      ivm_pkg::ST_DRIVE: begin
        if (!iack_active) begin
          next_state = ivm_pkg::ST_IDLE;
          next_vector_oe = 1'b0;
          next_dtack_n = 1'b1;
          next_dtack_oe = 1'b0;
        end
      end
      ivm_pkg::ST_PASSIVE: begin
        if (!iack_active) begin
          next_state = ivm_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = ivm_pkg::ST_IDLE;
        next_vector_oe = 1'b0;
        next_dtack_n = 1'b1;
        next_dtack_oe = 1'b0;
      end
    endcase
    next_strobe_n = 3'h7;
    if (iack_active && port_b_control[ivm_pkg::CTRL_STROBE_EN_BIT]) begin
      next_strobe_n[2] = (ack_level != ivm_pkg::LEVEL_7);
      next_strobe_n[1] = (ack_level != ivm_pkg::LEVEL_6);
      next_strobe_n[0] = (ack_level != ivm_pkg::LEVEL_1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ivm_pkg::ST_IDLE;
      vector_data_out <= 8'h00;
      vector_data_oe <= 1'b0;
      dtack_out_n <= 1'b1;
      dtack_oe <= 1'b0;
      internal_ack_valid <= 1'b0;
      internal_ack_code <= 5'h00;
      level7_ack_strobe_n <= 1'b1;
      level6_ack_strobe_n <= 1'b1;
      level1_ack_strobe_n <= 1'b1;
      ack_strobe_pins_en <= 1'b0;
      core_request_level <= 3'h0;
      forwarded_request_out_n <= 3'h7;
    end else begin
      state <= next_state;
      vector_data_out <= next_vector;
      vector_data_oe <= next_vector_oe;
      dtack_out_n <= next_dtack_n;
      dtack_oe <= next_dtack_oe;
      internal_ack_valid <= next_int_valid;
      internal_ack_code <= next_int_code;
      level7_ack_strobe_n <= next_strobe_n[2];
      level6_ack_strobe_n <= next_strobe_n[1];
      level1_ack_strobe_n <= next_strobe_n[0];
      ack_strobe_pins_en <= port_b_control[ivm_pkg::CTRL_STROBE_EN_BIT];
      core_request_level <= next_core_request_level;
      forwarded_request_out_n <= next_forwarded_n;
    end
  end

  // ==========================================================
  // apb slave: one wait state, answer registered
  assign apb_done = psel && penable && pready;
  assign apb_hit_mode = (paddr == ivm_pkg::MODE_ADDR);
  assign apb_hit_stat = (paddr == ivm_pkg::STATUS_ADDR);
  assign apb_hit_ctrl = (paddr == ivm_pkg::CTRL_ADDR);

  always_comb begin
    next_global_interrupt_mode = global_interrupt_mode;
    next_base_written = base_written;
    next_port_b_control = port_b_control;
    next_pready = 1'b0;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (psel && penable && !pready) begin
      next_pready = 1'b1;
      next_pslverr = !(apb_hit_mode || apb_hit_stat || apb_hit_ctrl);
      if (!pwrite) begin
        if (apb_hit_mode) begin
          next_prdata = {16'h0000, global_interrupt_mode};
        end else if (apb_hit_ctrl) begin
          next_prdata = {29'h0000_0000, port_b_control};
        end else if (apb_hit_stat) begin
          next_prdata[ivm_pkg::STAT_P1_BIT] = pend1;
          next_prdata[ivm_pkg::STAT_P6_BIT] = pend6;
          next_prdata[ivm_pkg::STAT_P7_BIT] = pend7;
          next_prdata[ivm_pkg::STAT_LEVEL_LSB +: 3] = core_request_level;
          next_prdata[ivm_pkg::STAT_VEC_LSB +: 8] = vector_data_out;
        end
      end
    end
    if (apb_done && pwrite) begin
      if (apb_hit_mode) begin
        next_global_interrupt_mode = pwdata[15:0] & ivm_pkg::MODE_WMASK;
        next_base_written = 1'b1;
      end
      if (apb_hit_ctrl) begin
        next_port_b_control = pwdata[2:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_interrupt_mode <= ivm_pkg::MODE_RESET;
      base_written <= 1'b0;
      port_b_control <= ivm_pkg::CTRL_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      global_interrupt_mode <= next_global_interrupt_mode;
      base_written <= next_base_written;
      port_b_control <= next_port_b_control;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule
`default_nettype wire

/* dv/ivm_vector_ctrl_monitor.sv */
// port-level checker for the vector and mode control block
`timescale 1ns/100ps
`default_nettype none
module ivm_vector_ctrl_monitor (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [15:0] internal_source_request, // level-4 sources
  input wire logic bus_addr_strobe, // address strobe
  input wire logic [2:0] bus_fc, // function code
  input wire logic [3:0] bus_addr_hi, // address high
  input wire logic [2:0] bus_addr_lo, // acknowledged level
  input wire logic [7:0] vector_data_out, // vector
  input wire logic vector_data_oe, // vector drive
  input wire logic dtack_out_n, // acknowledge
  input wire logic dtack_oe, // acknowledge drive
  input wire logic level7_ack_strobe_n, // level 7 strobe
  input wire logic level6_ack_strobe_n, // level 6 strobe
  input wire logic ack_strobe_pins_en, // strobe pins enabled
  input wire logic internal_ack_valid, // level-4 vector issued
  input wire logic [4:0] internal_ack_code // its code
);
  // ==========================================================
  // helpers
  wire dec = bus_addr_strobe && bus_fc == ivm_pkg::FC_IACK && bus_addr_hi == ivm_pkg::ADDR_HI_IACK;
  function automatic logic [4:0] code_of(input logic [2:0] l, input logic [15:0] r);
    code_of = 5'h00;
    if (l == 3'h7) code_of = 5'h17;
    else if (l == 3'h6) code_of = 5'h16;
    else if (l == 3'h1) code_of = 5'h11;
    else if (l == 3'h4) for (int i = 1; i < 16; i++) if (r[i]) code_of = i[4:0];
  endfunction
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup_access;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_ack_gone;
    dec ##1 !dec;
  endsequence
  // ==========================================================
  // assertions
  a_apb_wait: assert property (s_setup_access |=> pready)
    else $error("late apb answer");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_vec_dtack: assert property (vector_data_oe |-> dtack_oe && !dtack_out_n)
    else $error("vector without acknowledge");
  a_dtack_only_vec: assert property (dtack_oe |-> vector_data_oe)
    else $error("acknowledge without vector");
  a_vec_code: assert property ($rose(vector_data_oe) |-> vector_data_out == 8'h0f ||
    vector_data_out[4:0] == code_of($past(bus_addr_lo), $past(internal_source_request)))
    else $error("wrong vector code");
  a_no_code: assert property ($rose(dec) && bus_addr_lo inside {3'h2, 3'h3, 3'h5}
    |=> !vector_data_oe && !dtack_oe) else $error("vector on uncoded level");
  a_ack_release: assert property (s_ack_gone |=> !vector_data_oe && !dtack_oe)
    else $error("bus not released");
  a_int_code: assert property (internal_ack_valid |-> vector_data_oe &&
    internal_ack_code == code_of(3'h4, $past(internal_source_request)))
    else $error("wrong source code");
  a_valid_pulse: assert property (internal_ack_valid |=> !internal_ack_valid)
    else $error("valid held");
  a_strobe_l7: assert property (!level7_ack_strobe_n |->
    $past(dec) && $past(bus_addr_lo) == 3'h7 && ack_strobe_pins_en) else $error("stray strobe 7");
  a_strobe_l6: assert property (!level6_ack_strobe_n |->
    $past(dec) && $past(bus_addr_lo) == 3'h6 && ack_strobe_pins_en) else $error("stray strobe 6");
endmodule
bind ivm_vector_ctrl ivm_vector_ctrl_monitor mon (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .internal_source_request, .bus_addr_strobe, .bus_fc, .bus_addr_hi, .bus_addr_lo,
  .vector_data_out, .vector_data_oe, .dtack_out_n, .dtack_oe, .level7_ack_strobe_n,
  .level6_ack_strobe_n, .ack_strobe_pins_en, .internal_ack_valid, .internal_ack_code);
`default_nettype wire

/* dv/ivm_core_model.sv */
// behavioural core plus external peripheral on the acknowledge bus
`timescale 1ns/100ps
`default_nettype none
module ivm_core_model (
  input wire logic pclk, // clock
  input wire logic [7:0] vector_data_out, // device vector
  input wire logic vector_data_oe, // device drives data
  input wire logic dtack_out_n, // device acknowledge
  input wire logic dtack_oe, // device drives acknowledge
  input wire logic level7_ack_strobe_n, // strobe 7
  input wire logic level6_ack_strobe_n, // strobe 6
  input wire logic level1_ack_strobe_n, // strobe 1
  output logic bus_addr_strobe, // address strobe
  output logic [2:0] bus_fc, // function code
  output logic [3:0] bus_addr_hi, // address high
  output logic [2:0] bus_addr_lo, // level
  output logic autovector_request_n // autovector pin
);
  localparam logic [7:0] PERIPH_VECTOR = 8'h5a;
  logic [7:0] data_bus;
  logic [7:0] last_bus = 8'h00;
  logic periph_drv = 1'b0;
  logic dtack_n;
  logic [7:0] vec;
  logic owned;
  logic strobe_seen;
  initial begin
    bus_addr_strobe = 1'b0;
    bus_fc = 3'h0;
    bus_addr_hi = 4'h0;
    bus_addr_lo = 3'h0;
    autovector_request_n = 1'b1;
  end
  // undriven bus shows the inverse of its last value; acknowledge has a pull-up
  always_comb data_bus = vector_data_oe ? vector_data_out : periph_drv ? PERIPH_VECTOR : ~last_bus;
  always_comb dtack_n = dtack_oe ? dtack_out_n : !periph_drv;
  always @(posedge pclk) last_bus <= data_bus;
  task automatic ack(input logic [2:0] lvl, input logic ext, input logic av);
    int n = 0;
    strobe_seen = 1'b0;
    if (av) begin
      autovector_request_n <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    bus_fc <= 3'h7;
    bus_addr_hi <= 4'hf;
    bus_addr_lo <= lvl;
    bus_addr_strobe <= 1'b1;
    repeat (12) begin
      @(posedge pclk);
      n++;
      if (!(level7_ack_strobe_n && level6_ack_strobe_n && level1_ack_strobe_n)) strobe_seen = 1;
      if (!dtack_n || (av && n > 3)) break;
      periph_drv <= ext && !av && n >= 2;
    end
    vec = data_bus;
    owned = dtack_oe;
    bus_addr_strobe <= 1'b0;
    periph_drv <= 1'b0;
    autovector_request_n <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the vector and mode control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [15:0] mode; logic [2:0] ctrl; logic [15:0] isr; logic [2:0] lvl;
    logic ext; logic av; logic [7:0] vec; logic own;
  } ivm_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, autovector_request_n, bus_addr_strobe, vector_data_oe, dtack_out_n;
  logic level7_request_in_n = 1'b1, level6_request_in_n = 1'b1, level1_request_in_n = 1'b1;
  logic [2:0] encoded_priority_in_n = 3'h7, bus_fc, bus_addr_lo, core_request_level;
  logic [15:0] internal_source_request = 16'h0000;
  logic [3:0] bus_addr_hi;
  logic [2:0] forwarded_request_out_n;
  logic [7:0] vector_data_out;
  logic dtack_oe, level7_ack_strobe_n, level6_ack_strobe_n, level1_ack_strobe_n;
  logic ack_strobe_pins_en, internal_ack_valid;
  logic [4:0] internal_ack_code;
  int num_errors = 0, checks = 0;
  ivm_row_t rows [16] = '{
    '{16'h00a0, 3'h1, 16'h0000, 3'h7, 1'b0, 1'b0, 8'hb7, 1'b1},
    '{16'h00a0, 3'h1, 16'h0000, 3'h6, 1'b0, 1'b0, 8'hb6, 1'b1},
    '{16'h00a0, 3'h1, 16'h0000, 3'h1, 1'b0, 1'b0, 8'hb1, 1'b1},
    '{16'h00a0, 3'h0, 16'h8002, 3'h4, 1'b0, 1'b0, 8'haf, 1'b1},
    '{16'h00a0, 3'h0, 16'h3000, 3'h4, 1'b0, 1'b0, 8'had, 1'b1},
    '{16'h00a0, 3'h0, 16'h0002, 3'h4, 1'b0, 1'b0, 8'ha1, 1'b1},
    '{16'h00a0, 3'h0, 16'h0001, 3'h4, 1'b0, 1'b0, 8'ha0, 1'b1},
    '{16'h00a0, 3'h1, 16'h0000, 3'h2, 1'b0, 1'b0, 8'h00, 1'b0},
    '{16'h00a0, 3'h0, 16'h0000, 3'h3, 1'b0, 1'b0, 8'h00, 1'b0},
    '{16'h00a0, 3'h0, 16'h0000, 3'h5, 1'b0, 1'b0, 8'h00, 1'b0},
    '{16'h70a0, 3'h1, 16'h0000, 3'h7, 1'b1, 1'b0, 8'h5a, 1'b0},
    '{16'hf4a0, 3'h1, 16'h0000, 3'h6, 1'b1, 1'b0, 8'h5a, 1'b0},
    '{16'h10a0, 3'h0, 16'h0000, 3'h1, 1'b1, 1'b0, 8'h5a, 1'b0},
    '{16'h84a0, 3'h0, 16'h0000, 3'h1, 1'b0, 1'b0, 8'hb1, 1'b1},
    '{16'h00a0, 3'h4, 16'h8000, 3'h4, 1'b0, 1'b0, 8'h00, 1'b0},
    '{16'h00a0, 3'h6, 16'h8000, 3'h4, 1'b0, 1'b0, 8'haf, 1'b1}};
  always #4 pclk = ~pclk;
  ivm_vector_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .level7_request_in_n, .level6_request_in_n, .level1_request_in_n,
    .encoded_priority_in_n, .autovector_request_n, .internal_source_request, .bus_addr_strobe,
    .bus_fc, .bus_addr_hi, .bus_addr_lo, .core_request_level, .forwarded_request_out_n,
    .vector_data_out, .vector_data_oe, .dtack_out_n, .dtack_oe, .level7_ack_strobe_n,
    .level6_ack_strobe_n, .level1_ack_strobe_n, .ack_strobe_pins_en, .internal_ack_valid,
    .internal_ack_code);
  ivm_core_model core (.pclk, .vector_data_out, .vector_data_oe, .dtack_out_n, .dtack_oe,
    .level7_ack_strobe_n, .level6_ack_strobe_n, .level1_ack_strobe_n, .bus_addr_strobe,
    .bus_fc, .bus_addr_hi, .bus_addr_lo, .autovector_request_n);
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
    chk(32'(e), 32'(experr));
  endtask
  task automatic print_verdict;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(ivm_pkg::MODE_ADDR, 32'h0000_0000, 1'b0);
    core.ack(3'h7, 1'b0, 1'b0);
    chk(32'(core.vec), 32'h0000_000f);
    internal_source_request <= 16'h2000;
    core.ack(3'h4, 1'b0, 1'b0);
    chk(32'(core.vec), 32'h0000_000f);
    foreach (rows[i]) begin
      wr(ivm_pkg::MODE_ADDR, 32'(rows[i].mode));
      wr(ivm_pkg::CTRL_ADDR, 32'(rows[i].ctrl));
      internal_source_request <= rows[i].isr;
      core.ack(rows[i].lvl, rows[i].ext, rows[i].av);
      chk(32'(core.owned), 32'(rows[i].own));
      if (rows[i].own || rows[i].ext) chk(32'(core.vec), 32'(rows[i].vec));
      chk(32'(core.strobe_seen), 32'(rows[i].ctrl[0] && rows[i].lvl inside {7,6,1}));
    end
    core.ack(3'h6, 1'b0, 1'b1);
    chk(32'(core.owned), 32'h0000_0000);
    wr(ivm_pkg::MODE_ADDR, 32'hffff_ffff);
    rd(ivm_pkg::MODE_ADDR, 32'h0000_f7e0, 1'b0);
    rd(12'h00c, 32'h0000_0000, 1'b1);
    wr(ivm_pkg::MODE_ADDR, 32'h0000_00a0);
    encoded_priority_in_n <= 3'h1;
    repeat (6) @(posedge pclk);
    chk(32'(core_request_level), 32'h0000_0006);
    encoded_priority_in_n <= 3'h7;
    internal_source_request <= 16'h0000;
    wr(ivm_pkg::MODE_ADDR, 32'h0000_80a0);
    wr(ivm_pkg::CTRL_ADDR, 32'h0000_0004);
    level1_request_in_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'(core_request_level), 32'h0000_0001);
    chk(32'(forwarded_request_out_n), 32'h0000_0006);
    level1_request_in_n <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(32'(core_request_level), 32'h0000_0000);
    chk(32'(forwarded_request_out_n), 32'h0000_0007);
    wr(ivm_pkg::MODE_ADDR, 32'h0000_81a0);
    level1_request_in_n <= 1'b0;
    repeat (4) @(posedge pclk);
    level1_request_in_n <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(32'(core_request_level), 32'h0000_0001);
    core.ack(3'h1, 1'b0, 1'b0);
    chk(32'(core.vec), 32'h0000_00b1);
    repeat (4) @(posedge pclk);
    chk(32'(core_request_level), 32'h0000_0000);
    print_verdict();
  end
  initial begin
    #400000;
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
